// ---- hdl/pps_pkg.sv ----
package pps_pkg;

  // ****************************************************************
  // bus map
  // ****************************************************************
  localparam logic [7:0] OFF_STATUS = 8'h00; // mode and error summary
  localparam logic [7:0] OFF_ERRFLG = 8'h04; // sticky error causes, write one to clear
  localparam logic [7:0] OFF_CTRL = 8'h08; // host command strobes
  localparam logic [7:0] OFF_ACTIVE = 8'h0c; // settings in force
  localparam logic [7:0] OFF_NVSET = 8'h10; // stored power-on settings
  localparam logic [7:0] OFF_ALIGN = 8'h14; // stored alignment values

  localparam int CTRL_COLD = 0; // remote cold reset command
  localparam int CTRL_DEFAULTS = 1; // reset-defaults control code seen

  // ****************************************************************
  // error causes
  // ****************************************************************
  localparam int NERR = 5;
  localparam int ERR_FATAL = 0;
  localparam int ERR_POUT = 1;
  localparam int ERR_JAM = 2;
  localparam int ERR_EJECT = 3;
  localparam int ERR_LEVER = 4;

  // ****************************************************************
  // setting items, value index follows menu order
  // ****************************************************************
  localparam int NITEMS = 11;
  localparam logic [3:0] ITEM_LAST = 4'ha;
  localparam int IT_HSD = 0; // on, off
  localparam int IT_DIR = 1; // auto, bidirectional, unidirectional
  localparam int IT_EMUL = 2; // native, alternate
  localparam int IT_BUF = 3; // on, off
  localparam int IT_SKIP = 4; // on, off, others
  localparam int IT_TEAR = 5; // on, off
  localparam int IT_ALF = 6; // on, off
  localparam int IT_ACR = 7; // on, off
  localparam int IT_AGM = 8; // on, off
  localparam int IT_ZERO = 9; // on, off
  localparam int IT_BUZZ = 10; // on, off
  localparam logic [1:0] V_ON = 2'h0;
  localparam logic [1:0] V_OFF = 2'h1;
  localparam logic [1:0] V_BIDIR = 2'h1;
  localparam logic [1:0] V_ALT_EMUL = 2'h1;
  // factory image, item 0 in the low bits
  localparam logic [21:0] FACTORY = {
    V_ON, V_OFF, V_OFF, V_OFF, V_OFF, V_OFF, V_OFF, V_ON, 2'h0, V_BIDIR, V_ON};

  localparam logic [2:0] LANG_LAST = 3'h4; // five guide languages
  localparam int NALIGN = 3; // draft, draft copy, letter quality
  localparam logic [1:0] ALN_LQ = 2'h2;
  localparam logic [4:0] ALN_MAX = 5'h1a; // 27 three-led patterns
  localparam logic [4:0] ALN_START = 5'h0d; // middle pattern

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {LED_OFF, LED_ON, LED_BLINK} pps_lmode_t;

  typedef struct packed {
    logic pause;
    logic load;
    logic lf;
    logic tear;
    logic font;
    logic cond;
  } pps_sw_t;

  typedef struct packed {
    pps_lmode_t font2;
    pps_lmode_t font1;
    pps_lmode_t font0;
    pps_lmode_t cond;
    pps_lmode_t tear1;
    pps_lmode_t tear0;
  } pps_led_t;

  typedef struct packed {
    logic carriage_fail;
    logic volt_fault;
    logic cgmem_fail;
    logic load_fail;
    logic eject_fail;
    logic feed_fail;
    logic lever_mismatch;
  } pps_fault_t;

  typedef enum logic [2:0] {
    JOB_NONE, JOB_LANG_SHEET, JOB_GUIDE_SHEET, JOB_ALN_GUIDE, JOB_ALN_PATTERN
  } pps_job_t;

  typedef enum logic [3:0] {
    ST_BOOT, ST_MECH, ST_NORMAL, ST_LPRINT, ST_LANG, ST_GPRINT, ST_MAIN, ST_SUB,
    ST_AGUIDE, ST_APAT, ST_ASEL, ST_ADONE
  } pps_state_t;

endpackage

// ---- hdl/pps_press.sv ----
`timescale 1ns/1ps
// turns held switch levels into one-cycle press pulses
module pps_press
  import pps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pps_sw_t sw,
  output pps_sw_t press
);

  pps_sw_t last_r;

  // remember the previous level; a press is a rising level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= '0;
    end else begin
      last_r <= sw;
    end
  end

  // a strap held through release gives one press once the sequencer has left boot for a sheet or mechanism wait,
  // so power-on straps never step a menu
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press <= '0;
    end else begin
      press <= sw & ~last_r;
    end
  end

endmodule

// ---- hdl/pps_top.sv ----
`timescale 1ns/1ps
module pps_top
  import pps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pps_sw_t sw,
  input wire pps_fault_t fault,
  input wire logic init_n,
  input wire logic cold_cmd,
  input wire logic defaults_code,
  input wire logic mech_done,
  input wire logic print_done,
  output pps_led_t led,
  output logic error_n,
  output logic busy,
  output logic accept_data,
  output logic print_enable,
  output logic mech_init,
  output logic clear_buffers,
  output logic discard_download,
  output logic discard_unprinted,
  output logic standby,
  output logic print_req,
  output pps_job_t print_job,
  output logic [1:0] align_phase,
  output logic [4:0] align_number,
  output logic auto_cr_on,
  output logic alt_graphics_on
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // base-three digit shown on one led: off, on, blink
  function automatic pps_lmode_t tern(input logic [4:0] n, input int d);
    logic [4:0] q;
    q = n;
    for (int i = 0; i < d; i++) begin
      q = q / 5'h3;
    end
    case (q % 5'h3)
      5'h0: tern = LED_OFF;
      5'h1: tern = LED_ON;
      default: tern = LED_BLINK;
    endcase
  endfunction

  // last value index of a setting item
  function automatic logic [1:0] last_val(input logic [3:0] it);
    if (it == 4'(IT_DIR) || it == 4'(IT_SKIP)) begin
      last_val = 2'h2;
    end else begin
      last_val = 2'h1;
    end
  endfunction

  function automatic pps_lmode_t onoff(input logic b);
    onoff = b ? LED_ON : LED_OFF;
  endfunction

  pps_sw_t press;
  pps_state_t state_r;
  logic [2:0] lang_r;
  logic [3:0] item_r;
  logic [1:0] val_r;
  logic [1:0] nv_r [NITEMS];
  logic [1:0] act_r [NITEMS];
  logic [4:0] aln_r [NALIGN];
  logic [4:0] sel_r;
  logic [1:0] phase_r;
  logic [NERR-1:0] flags_r;
  logic init_last_r;
  logic init_fall;
  logic cold_go;
  logic dflt_go;
  logic wr_en;
  logic err_any;
  logic setup_mode;

  pps_press u_press (
    .pclk(pclk),
    .presetn(presetn),
    .sw(sw),
    .press(press)
  );

  // ****************************************************************
  // host events and bus strobes
  // ****************************************************************
  // access phase is zero-wait: pready is raised by the setup edge
  assign wr_en = psel && penable && pready && pwrite;
  assign cold_go = cold_cmd || (wr_en && paddr == OFF_CTRL && pwdata[CTRL_COLD]);
  assign dflt_go = defaults_code || (wr_en && paddr == OFF_CTRL && pwdata[CTRL_DEFAULTS]);
  assign init_fall = init_last_r && !init_n;
  assign err_any = |flags_r;
  assign setup_mode = state_r inside {ST_LPRINT, ST_LANG, ST_GPRINT, ST_MAIN, ST_SUB,
                                      ST_AGUIDE, ST_APAT, ST_ASEL, ST_ADONE};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_last_r <= 1'b1;
    end else begin
      init_last_r <= init_n;
    end
  end

  // ****************************************************************
  // mode sequencer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_BOOT;
      lang_r <= '0;
      item_r <= '0;
      val_r <= '0;
      sel_r <= ALN_START;
      phase_r <= '0;
    end else begin
      case (state_r)
        // straps are sampled on the first edge after release
        ST_BOOT: begin
          if (sw.font) begin
            state_r <= ST_LPRINT;
          end else if (sw.pause) begin
            state_r <= ST_AGUIDE;
          end else begin
            state_r <= ST_MECH;
          end
        end
        ST_MECH: if (mech_done) begin
          state_r <= ST_NORMAL;
        end
        ST_NORMAL: if (cold_go) begin
          state_r <= ST_MECH;
        end
        ST_LPRINT: if (print_done) begin
          state_r <= ST_LANG;
        end
        ST_LANG: begin
          if (press.tear) begin
            state_r <= ST_GPRINT;
          end else if (press.font) begin
            lang_r <= (lang_r == LANG_LAST) ? 3'h0 : lang_r + 3'h1;
          end
        end
        ST_GPRINT: if (print_done) begin
          state_r <= ST_MAIN;
          item_r <= '0;
        end
        ST_MAIN: begin
          if (press.tear) begin
            state_r <= ST_SUB;
            val_r <= nv_r[item_r];
          end else if (press.font) begin
            item_r <= (item_r == ITEM_LAST) ? 4'h0 : item_r + 4'h1;
          end
        end
        // font confirms the shown value, tear steps it
        ST_SUB: begin
          if (press.font) begin
            state_r <= ST_MAIN;
          end else if (press.tear) begin
            val_r <= (val_r == last_val(item_r)) ? 2'h0 : val_r + 2'h1;
          end
        end
        ST_AGUIDE: if (print_done) begin
          state_r <= ST_APAT;
        end
        ST_APAT: if (print_done) begin
          state_r <= ST_ASEL;
          sel_r <= ALN_START;
        end
        ST_ASEL: begin
          if (press.font) begin
            // phase stops at letter quality so the stored-value lookup stays in range
            if (phase_r != ALN_LQ) begin
              phase_r <= phase_r + 2'h1;
            end
            state_r <= (phase_r == ALN_LQ) ? ST_ADONE : ST_APAT;
          end else if (press.lf && sel_r != '0) begin
            sel_r <= sel_r - 5'h1;
          end else if (press.load && sel_r != ALN_MAX) begin
            sel_r <= sel_r + 5'h1;
          end
        end
        ST_ADONE: state_r <= ST_ADONE;
        default: state_r <= ST_BOOT;
      endcase
    end
  end

  // ****************************************************************
  // stored settings; the power-on image is reset only to factory values
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NITEMS; i++) begin
        nv_r[i] <= FACTORY[2*i +: 2];
      end
    end else if (state_r == ST_SUB && press.font) begin
      nv_r[item_r] <= val_r;
    end
  end

  // settings in force load from the image at boot only, and reset first refills the image with factory values, so edits never reach them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NITEMS; i++) begin
        act_r[i] <= FACTORY[2*i +: 2];
      end
    end else if (state_r == ST_BOOT) begin
      act_r <= nv_r;
    end else if (dflt_go && state_r == ST_NORMAL) begin
      for (int i = 0; i < NITEMS; i++) begin
        act_r[i] <= FACTORY[2*i +: 2];
      end
    end
  end

  // alignment lives apart from the settings image and is never defaulted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NALIGN; i++) begin
        aln_r[i] <= ALN_START;
      end
    end else if (state_r == ST_ASEL && press.font) begin
      aln_r[phase_r] <= sel_r;
    end
  end

  // ****************************************************************
  // error causes: hardware set wins over a software clear
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
    end else begin
      logic [NERR-1:0] set;
      set = '0;
      set[ERR_FATAL] = fault.carriage_fail | fault.volt_fault | fault.cgmem_fail;
      set[ERR_POUT] = fault.load_fail;
      set[ERR_EJECT] = fault.eject_fail;
      set[ERR_JAM] = fault.feed_fail;
      set[ERR_LEVER] = fault.lever_mismatch;
      if (wr_en && paddr == OFF_ERRFLG) begin
        flags_r <= (flags_r & ~pwdata[NERR-1:0]) | set;
      end else begin
        flags_r <= flags_r | set;
      end
    end
  end

  // ****************************************************************
  // host-facing outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_n <= 1'b1;
      busy <= 1'b1;
      accept_data <= 1'b0;
      print_enable <= 1'b0;
      standby <= 1'b0;
    end else begin
      error_n <= !err_any;
      busy <= err_any || state_r != ST_NORMAL;
      accept_data <= !err_any && state_r == ST_NORMAL;
      print_enable <= !err_any && state_r != ST_BOOT && state_r != ST_MECH;
      if ((init_fall && !setup_mode) || (state_r == ST_MECH && mech_done)) begin
        standby <= !err_any;
      end else if (err_any || state_r != ST_NORMAL) begin
        standby <= 1'b0;
      end
    end
  end

  // initialisation pulses, one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mech_init <= 1'b0;
      clear_buffers <= 1'b0;
      discard_download <= 1'b0;
      discard_unprinted <= 1'b0;
    end else begin
      logic oper;
      oper = (init_fall && !setup_mode) || (state_r == ST_MECH && mech_done);
      mech_init <= state_r == ST_BOOT && !sw.font && !sw.pause
                   || state_r == ST_NORMAL && cold_go;
      clear_buffers <= oper;
      discard_download <= oper;
      discard_unprinted <= oper || (dflt_go && state_r == ST_NORMAL);
    end
  end

  // print requests hold until the mechanism reports the sheet done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      print_req <= 1'b0;
      print_job <= JOB_NONE;
    end else begin
      case (state_r)
        ST_LPRINT: print_job <= JOB_LANG_SHEET;
        ST_GPRINT: print_job <= JOB_GUIDE_SHEET;
        ST_AGUIDE: print_job <= JOB_ALN_GUIDE;
        ST_APAT: print_job <= JOB_ALN_PATTERN;
        default: print_job <= JOB_NONE;
      endcase
      print_req <= state_r inside {ST_LPRINT, ST_GPRINT, ST_AGUIDE, ST_APAT} && !print_done;
    end
  end

  // ****************************************************************
  // panel leds and applied options
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= '0;
      align_phase <= '0;
      align_number <= '0;
      auto_cr_on <= 1'b0;
      alt_graphics_on <= 1'b0;
    end else begin
      logic [4:0] shown;
      logic alt;
      shown = (state_r == ST_LANG) ? {2'h0, lang_r} : {1'h0, item_r};
      if (state_r inside {ST_ASEL, ST_APAT}) begin
        shown = sel_r;
      end
      led.font0 <= tern(shown, 0);
      led.font1 <= tern(shown, 1);
      led.font2 <= tern(shown, 2);
      led.cond <= onoff(state_r == ST_SUB && val_r[1]);
      led.tear1 <= onoff(state_r == ST_SUB && val_r[0]);
      led.tear0 <= onoff(state_r == ST_SUB);
      align_phase <= phase_r;
      align_number <= aln_r[phase_r];
      alt = act_r[IT_EMUL] == V_ALT_EMUL;
      auto_cr_on <= alt && act_r[IT_ACR] == V_ON;
      alt_graphics_on <= alt && act_r[IT_AGM] == V_ON;
    end
  end

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      logic [31:0] rd;
      logic bad;
      rd = '0;
      bad = 1'b0;
      case (paddr)
        OFF_STATUS: rd = {22'h0, err_any, setup_mode, 4'(state_r), 4'(phase_r)};
        OFF_ERRFLG: rd = {27'h0, flags_r};
        OFF_CTRL: rd = '0;
        OFF_ACTIVE: for (int i = 0; i < NITEMS; i++) rd[2*i +: 2] = act_r[i];
        OFF_NVSET: for (int i = 0; i < NITEMS; i++) rd[2*i +: 2] = nv_r[i];
        OFF_ALIGN: for (int i = 0; i < NALIGN; i++) rd[8*i +: 5] = aln_r[i];
        default: bad = 1'b1;
      endcase
      pready <= psel && !penable;
      pslverr <= psel && !penable && bad;
      prdata <= (psel && !penable && !pwrite && !bad) ? rd : 32'h0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_err_drives_pins: assert property (@(posedge pclk) disable iff (!presetn)
    (|flags_r) |=> (!error_n && busy && !accept_data && !print_enable))
    else $error("error state not shown on host pins");

  a_fatal_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (fault.carriage_fail || fault.volt_fault || fault.cgmem_fail) |=> flags_r[ERR_FATAL])
    else $error("fatal cause did not raise fatal flag");

  a_feed_is_jam: assert property (@(posedge pclk) disable iff (!presetn)
    (fault.feed_fail && !fault.load_fail) |=> (flags_r[ERR_JAM] ##1 error_n == 1'b0))
    else $error("failed feed not reported as jam");

  a_setup_stays_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_mode && $past(setup_mode)) |=> (busy && !accept_data && $stable(setup_mode)))
    else $error("settings or alignment mode let host data in");

  a_align_step_up: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_ASEL && press.load && !press.font && !press.lf && sel_r != ALN_MAX)
    |=> sel_r == $past(sel_r) + 5'h1)
    else $error("load press did not raise pattern number");

  a_boot_pause_align: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_BOOT && sw.pause && !sw.font) |=> state_r == ST_AGUIDE ##1
    (print_req && print_job == JOB_ALN_GUIDE))
    else $error("pause strap did not start alignment guide");

  a_init_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (init_fall && !setup_mode) |=> (clear_buffers && discard_download) ##1 !clear_buffers)
    else $error("host init pulse did not clear buffers for one cycle");

  a_cold_mech: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_NORMAL && cold_go) |=> (mech_init && state_r == ST_MECH))
    else $error("cold command did not restart mechanism");

  a_submenu_store: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_SUB && press.font) |=> (state_r == ST_MAIN && nv_r[item_r] == $past(val_r)))
    else $error("confirmed value not stored");

endmodule

// ---- verification/pps_far_model.sv ----
`timescale 1ns/1ps
// stands in for the print engine: answers sheet and mechanism requests
module pps_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic print_req,
  input wire logic mech_init,
  output logic print_done,
  output logic mech_done
);
  int cnt;
  logic slow;
  logic mpend;
  // alternate prompt and slow answers so every waiting state really waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      slow <= 1'b0;
      mpend <= 1'b0;
      print_done <= 1'b0;
      mech_done <= 1'b0;
    end else begin
      print_done <= 1'b0;
      mech_done <= 1'b0;
      if (mech_init) mpend <= 1'b1;
      if ((print_req || mpend) && !print_done && !mech_done) begin
        cnt <= cnt + 1;
        if (cnt >= (slow ? 6 : 1)) begin
          cnt <= 0;
          slow <= !slow;
          print_done <= print_req;
          mech_done <= mpend;
          mpend <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- verification/pps_top_tb.sv ----
`timescale 1ns/1ps
module pps_top_tb;
  import pps_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, init_n, cold_cmd, defaults_code;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, error_n, busy, accept_data, print_enable, mech_init, clear_buffers;
  logic discard_download, discard_unprinted, standby, print_req, mech_done, print_done;
  logic auto_cr_on, alt_graphics_on;
  logic [1:0] align_phase;
  logic [4:0] align_number;
  logic [2:0] pulses;
  pps_sw_t sw;
  pps_fault_t fault;
  pps_led_t led;
  pps_job_t print_job;
  logic [32:0] expq[$];
  int errors = 0, n_checks = 0, cycles = 0, seed;
  int ef[7] = '{ERR_LEVER, ERR_JAM, ERR_EJECT, ERR_POUT, ERR_FATAL, ERR_FATAL, ERR_FATAL};

  pps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sw(sw), .fault(fault), .init_n(init_n), .cold_cmd(cold_cmd),
    .defaults_code(defaults_code), .mech_done(mech_done), .print_done(print_done),
    .led(led), .error_n(error_n), .busy(busy), .accept_data(accept_data),
    .print_enable(print_enable), .mech_init(mech_init), .clear_buffers(clear_buffers),
    .discard_download(discard_download), .discard_unprinted(discard_unprinted),
    .standby(standby), .print_req(print_req), .print_job(print_job),
    .align_phase(align_phase), .align_number(align_number), .auto_cr_on(auto_cr_on),
    .alt_graphics_on(alt_graphics_on));
  pps_far_model far (.pclk(pclk), .presetn(presetn), .print_req(print_req),
    .mech_init(mech_init), .print_done(print_done), .mech_done(mech_done));
  assign pulses = {mech_init, discard_unprinted, clear_buffers};

  // ****************************************************************
  // clock, hang guard and checking
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // the whole run needs a few hundred cycles, so this only trips on a hang
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_checks = n_checks + 1;
    if (ok !== 1'b1) begin
      errors = errors + 1;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // read answers are matched against the oldest note left by the driver
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (expq.size() == 0) chk(1'b0, "read answer without a note");
      else chk({pslverr, prdata} === expq.pop_front(), "read data or response differs");
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k = k + 1;
    end while (pready !== 1'b1 && k < 20);
    chk(pready === 1'b1, "no ready from slave");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input pps_sw_t s);
    presetn <= 1'b0;
    sw <= s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sw <= '0;
  endtask
  task automatic press(input pps_sw_t s);
    sw <= s;
    @(posedge pclk);
    sw <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic job(input pps_job_t j);
    int k;
    k = 0;
    @(negedge pclk);
    while (print_req !== 1'b1 && k < 60) begin
      @(negedge pclk);
      k = k + 1;
    end
    chk(print_req === 1'b1 && print_job === j, "sheet not requested");
    while (print_req === 1'b1 && k < 120) begin
      @(negedge pclk);
      k = k + 1;
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic waitp(input int s);
    int k;
    k = 0;
    while (pulses[s] !== 1'b1 && k < 20) begin
      @(negedge pclk);
      k = k + 1;
    end
    chk(pulses[s] === 1'b1, "expected pulse missing");
    @(posedge pclk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    seed = 32'h2032;
    {presetn, psel, penable, pwrite, cold_cmd, defaults_code} = '0;
    {paddr, pwdata, sw, fault} = '0;
    init_n = 1'b1;
    boot('0);
    apb(1'b0, OFF_ACTIVE, '0, {11'h0, FACTORY});
    chk(auto_cr_on === 1'b0 && alt_graphics_on === 1'b0, "options on under native set");
    rd = $random(seed);
    apb(1'b1, 8'h40, rd, '0);
    apb(1'b0, 8'h3c, '0, 33'h100000000);
    for (int i = 0; i < 7; i++) begin
      fault <= pps_fault_t'(7'h1 << i);
      @(posedge pclk);
      fault <= '0;
      repeat (3) @(posedge pclk);
      chk(error_n === 1'b0 && busy === 1'b1 && accept_data === 1'b0, "error state");
      chk(print_enable === 1'b0, "printing still allowed");
      apb(1'b0, OFF_ERRFLG, '0, {1'b0, 32'h1 << ef[i]});
      rd = $random(seed);
      apb(1'b1, OFF_ERRFLG, rd | 32'h1f, '0);
    end
    repeat (3) @(posedge pclk);
    init_n <= 1'b0;
    waitp(0);
    init_n <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(standby === 1'b1, "no standby after host init");
    defaults_code <= 1'b1;
    @(posedge pclk);
    defaults_code <= 1'b0;
    waitp(1);
    apb(1'b1, OFF_CTRL, 32'h1, '0);
    waitp(2);
    waitp(0);
    boot('{font: 1'b1, default: 1'b0});
    job(JOB_LANG_SHEET);
    chk(busy === 1'b1, "host data taken in settings");
    press('{tear: 1'b1, default: 1'b0});
    job(JOB_GUIDE_SHEET);
    press('{tear: 1'b1, default: 1'b0});
    press('{cond: 1'b1, default: 1'b0});
    press('{tear: 1'b1, default: 1'b0});
    chk(led.tear1 === LED_ON && led.cond === LED_OFF, "submenu value shown");
    press('{font: 1'b1, default: 1'b0});
    apb(1'b0, OFF_NVSET, '0, {11'h0, FACTORY ^ 22'h1});
    boot('{pause: 1'b1, default: 1'b0});
    job(JOB_ALN_GUIDE);
    job(JOB_ALN_PATTERN);
    chk(align_number === 5'h0d && align_phase === 2'h0, "alignment start");
    press('{load: 1'b1, default: 1'b0});
    press('{load: 1'b1, default: 1'b0});
    press('{lf: 1'b1, default: 1'b0});
    chk(led.font0 === LED_BLINK && led.font1 === LED_ON && led.font2 === LED_ON
        && align_number === 5'h0d, "alignment step");
    press('{font: 1'b1, default: 1'b0});
    job(JOB_ALN_PATTERN);
    chk(align_phase === 2'h1, "next alignment phase");
    apb(1'b0, OFF_ALIGN, '0, 33'h000d0d0e);
    repeat (2) @(posedge pclk);
    chk(expq.size() == 0, "read notes left unanswered");
    complete_run();
  end
endmodule
